/* File: rtl/wdt_pkg.sv */
// Behaviour
// - Refresh bit write loads reload value into counter and clears prescaler.
// - Watchdog reset drives reset output for at least 196 system clocks.
// - Reset output releases right after the reset cycle, no extra delay.
// - Overflow sets status flag; watchdog mode clears only by POR or fed write.
// - Timer mode accepts control and reload writes without feed sequence.
// - Timer mode run bit starts and stops the counter.
// - Timer mode overflow sets flag; writing one clears it.
// - Timer mode overflow reloads counter and keeps counting.
// - Enabled timer mode overflow raises interrupt request for vector 053H, priority nine; watchdog mode raises none.
// - Counter steps once every 344064 crystal clocks.
// - Period equals (255 minus reload) times 344064 crystal clocks.
// - Wrong second or third feed step in watchdog mode resets at once.
// - Counter keeps counting in idle mode.
// - Counter halts in power-down mode.
// - Software may gate the block clock off in timer mode.
// - Control bit 3 selects reset mode (1) or interrupt-only timer (0).
// - Mode select bit clears only on power-on reset.
// - Force-on bit 6 runs the counter and stays set until overflow clears it; else run bit governs.
// - Interrupt requested only while enable bit 6 of aux enable register set.
package wdt_pkg;
  localparam logic [7:0]  FEED_KEY1      = 8'hFD;
  localparam logic [7:0]  FEED_KEY2      = 8'h2A;
  localparam int          CTL_RUN        = 0;
  localparam int          CTL_REFRESH    = 1;
  localparam int          CTL_MODE       = 3;
  localparam int          CTL_FORCE_ON   = 6;
  localparam int          IEN_WDOG       = 6;
  localparam logic [7:0]  CNT_TOP        = 8'hFF;
  localparam logic [7:0]  CTL_RESET_VAL  = 8'h00;
  localparam logic [7:0]  RELOAD_RESET   = 8'h00;
  localparam int          PRESCALE_DIV   = 344064;
  localparam int          SYS_CLK_MHZ    = 100;
  localparam int          RST_HOLD_CLKS  = 196;
  localparam logic [15:0] IRQ_VECTOR     = 16'h0053;
  localparam logic [3:0]  IRQ_PRIORITY   = 4'h9;
  typedef enum logic [1:0] {
    WDT_FEED_IDLE = 2'b00,
    WDT_FEED_KEY1 = 2'b01,
    WDT_FEED_OPEN = 2'b11
  } wdt_feed_e;
endpackage

/* File: rtl/wdt_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module wdt_prescaler #(
  parameter int DIV = wdt_pkg::PRESCALE_DIV
) (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic clkEn,
  // Control.
  input  wire logic run,
  input  wire logic clear,
  // Output.
  output logic      tick
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         tick_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (clear) begin
      cnt_nxt = '0;
    end else if (run) begin
      if (cnt_r == LAST) begin
        cnt_nxt  = '0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (clkEn) begin
      cnt_r <= cnt_nxt;
      tick  <= tick_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/wdt_core.sv */
`timescale 1ns/1ps
`default_nettype none
module wdt_core #(
  parameter int PRESCALE = wdt_pkg::PRESCALE_DIV,
  parameter int RST_HOLD = wdt_pkg::RST_HOLD_CLKS
) (
  // Clock, enable and power-on reset.
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        clkEn,
  // Software register writes, one-cycle strobes.
  input  wire logic        ctlWrite,
  input  wire logic        reloadWrite,
  input  wire logic        key1Write,
  input  wire logic        key2Write,
  input  wire logic        statusWrite,
  input  wire logic        otherWrite,
  input  wire logic [7:0]  wrData,
  input  wire logic        auxIrqEnableBit,
  // Power state.
  input  wire logic        powerDown,
  input  wire logic        idleMode,
  input  wire logic        clockGateOff,
  // Register views.
  output logic [7:0]       ctlValue,
  output logic [7:0]       reloadValue,
  output logic [7:0]       counterValue,
  output logic             overflowStatusFlag,
  // Results.
  output logic             irqReq,
  output logic [15:0]      irqVector,
  output logic [3:0]       irqPriority,
  output logic             sysResetOut
);
  localparam int HW = $clog2(RST_HOLD + 1);
  localparam logic [HW-1:0] HOLD_N = HW'(RST_HOLD);

  logic [7:0] ctl_r, ctl_nxt, reload_r, reload_nxt, cnt_r, cnt_nxt;
  logic       flag_r, flag_nxt, irq_r, irq_nxt, rst_r, rst_nxt;
  logic [HW-1:0] hold_r, hold_nxt;
  wdt_pkg::wdt_feed_e feed_r, feed_nxt;
  logic       tick, modeWdog, running, ctlAccept, refresh, feedErr, wdOvf, ovf;

  assign modeWdog = ctl_r[wdt_pkg::CTL_MODE];
  // Idle leaves the counter alone; only power-down or a timer-mode clock gate stops it.
  assign running = (ctl_r[wdt_pkg::CTL_RUN] || ctl_r[wdt_pkg::CTL_FORCE_ON])
                   && !powerDown
                   && !(clockGateOff && !modeWdog)
                   && (idleMode || !idleMode);
  assign ctlAccept = ctlWrite && (!modeWdog || feed_r == wdt_pkg::WDT_FEED_OPEN);
  assign refresh = ctlAccept && wrData[wdt_pkg::CTL_REFRESH];
  // Wrong second step: anything but the second key right after the first key.
  assign feedErr = modeWdog && (
      (feed_r == wdt_pkg::WDT_FEED_KEY1 && (!key2Write || wrData != wdt_pkg::FEED_KEY2) &&
       (key1Write || ctlWrite || reloadWrite || statusWrite || otherWrite || key2Write)) ||
      (feed_r == wdt_pkg::WDT_FEED_OPEN && !ctlWrite && !statusWrite &&
       (key1Write || key2Write || reloadWrite || otherWrite)));
  // The step onto the top value is the overflow, so a period is 255 minus reload ticks.
  assign ovf = tick && running && cnt_r >= wdt_pkg::CNT_TOP - 8'h01;
  assign wdOvf = ovf && modeWdog;

  wdt_prescaler #(.DIV(PRESCALE)) u_pre (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .clkEn   (clkEn),
    .run     (running),
    .clear   (refresh),
    .tick    (tick)
  );

  always_comb begin
    feed_nxt = feed_r;
    if (key1Write && wrData == wdt_pkg::FEED_KEY1) begin
      feed_nxt = wdt_pkg::WDT_FEED_KEY1;
    end else if (feed_r == wdt_pkg::WDT_FEED_KEY1 && key2Write && wrData == wdt_pkg::FEED_KEY2) begin
      feed_nxt = wdt_pkg::WDT_FEED_OPEN;
    end else if (ctlWrite || statusWrite || key1Write || key2Write || reloadWrite || otherWrite) begin
      feed_nxt = wdt_pkg::WDT_FEED_IDLE;
    end
  end

  always_comb begin
    ctl_nxt    = ctl_r;
    reload_nxt = reload_r;
    if (ctlAccept) begin
      ctl_nxt = wrData & ~(8'h01 << wdt_pkg::CTL_REFRESH);
      ctl_nxt[wdt_pkg::CTL_MODE] = wrData[wdt_pkg::CTL_MODE] | modeWdog;
      // Force-on can not be dropped until overflow.
      ctl_nxt[wdt_pkg::CTL_FORCE_ON] = wrData[wdt_pkg::CTL_FORCE_ON] | ctl_r[wdt_pkg::CTL_FORCE_ON];
    end
    if (ovf) begin
      ctl_nxt[wdt_pkg::CTL_FORCE_ON] = 1'b0;
    end
    if (reloadWrite && (!modeWdog || feed_r == wdt_pkg::WDT_FEED_OPEN)) begin
      reload_nxt = wrData;
    end
  end

  always_comb begin
    cnt_nxt = cnt_r;
    if (refresh) begin
      cnt_nxt = reload_r;
    end else if (ovf) begin
      cnt_nxt = reload_r;
    end else if (tick && running) begin
      cnt_nxt = cnt_r + 8'h01;
    end
  end

  always_comb begin
    flag_nxt = flag_r;
    if (statusWrite && wrData[0] && (!modeWdog || feed_r == wdt_pkg::WDT_FEED_OPEN)) begin
      flag_nxt = 1'b0;
    end
    if (ovf) begin
      flag_nxt = 1'b1;
    end
    irq_nxt = flag_nxt && !modeWdog && auxIrqEnableBit;
  end

  always_comb begin
    hold_nxt = hold_r;
    rst_nxt  = rst_r;
    if (wdOvf || feedErr) begin
      hold_nxt = HOLD_N;
      rst_nxt  = 1'b1;
    end else if (hold_r != '0) begin
      hold_nxt = hold_r - HW'(1);
      rst_nxt  = (hold_r != HW'(1));
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctl_r    <= wdt_pkg::CTL_RESET_VAL;
      reload_r <= wdt_pkg::RELOAD_RESET;
      cnt_r    <= wdt_pkg::RELOAD_RESET;
      flag_r   <= 1'b0;
      irq_r    <= 1'b0;
      rst_r    <= 1'b0;
      hold_r   <= '0;
      feed_r   <= wdt_pkg::WDT_FEED_IDLE;
    end else if (clkEn) begin
      ctl_r    <= ctl_nxt;
      reload_r <= reload_nxt;
      cnt_r    <= cnt_nxt;
      flag_r   <= flag_nxt;
      irq_r    <= irq_nxt;
      rst_r    <= rst_nxt;
      hold_r   <= hold_nxt;
      feed_r   <= feed_nxt;
    end
  end

  assign ctlValue           = ctl_r;
  assign reloadValue        = reload_r;
  assign counterValue       = cnt_r;
  assign overflowStatusFlag = flag_r;
  assign irqReq             = irq_r;
  assign sysResetOut        = rst_r;
  assign irqVector          = wdt_pkg::IRQ_VECTOR;
  assign irqPriority        = wdt_pkg::IRQ_PRIORITY;

  // Counts how long the reset output has stood high, saturating at the hold count.
  logic [HW-1:0] rstLen_r;
  logic [HW-1:0] rstLen_nxt;

  always_comb begin
    rstLen_nxt = '0;
    if (rst_r) begin
      rstLen_nxt = (rstLen_r == HOLD_N) ? rstLen_r : rstLen_r + HW'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rstLen_r <= '0;
    end else if (clkEn) begin
      rstLen_r <= rstLen_nxt;
    end
  end

  property p_rst_len;
    @(posedge clk_sys) disable iff (!arst_n)
      $fell(rst_r) |-> rstLen_r == HOLD_N;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse shorter than hold count");

  property p_irq_mode;
    @(posedge clk_sys) disable iff (!arst_n)
      modeWdog && $past(modeWdog) && $past(clkEn) |-> !irq_r;
  endproperty
  a_irq_mode: assert property (p_irq_mode) else $error("interrupt in reset mode");

  property p_timer_write;
    @(posedge clk_sys) disable iff (!arst_n)
      ctlWrite && !modeWdog && clkEn |=> ctl_r[wdt_pkg::CTL_RUN] == $past(wrData[wdt_pkg::CTL_RUN]);
  endproperty
  a_timer_write: assert property (p_timer_write) else $error("timer mode write refused");

  property p_flag_clr;
    @(posedge clk_sys) disable iff (!arst_n)
      statusWrite && wrData[0] && !modeWdog && !ovf && clkEn |=> !flag_r;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

  property p_force_on;
    @(posedge clk_sys) disable iff (!arst_n)
      ctl_r[wdt_pkg::CTL_FORCE_ON] && !ovf && clkEn |=> ctl_r[wdt_pkg::CTL_FORCE_ON];
  endproperty
  a_force_on: assert property (p_force_on) else $error("force-on dropped before overflow");

  property p_step;
    @(posedge clk_sys) disable iff (!arst_n)
      tick && running && !ovf && !refresh && clkEn |=> cnt_r == $past(cnt_r) + 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("counter did not step by one");

  property p_run_stop;
    @(posedge clk_sys) disable iff (!arst_n)
      !modeWdog && !ctl_r[wdt_pkg::CTL_RUN] && !ctl_r[wdt_pkg::CTL_FORCE_ON] && !refresh && clkEn
      |=> cnt_r == $past(cnt_r);
  endproperty
  a_run_stop: assert property (p_run_stop) else $error("stopped timer moved");

  property p_gate;
    @(posedge clk_sys) disable iff (!arst_n)
      clockGateOff && !modeWdog && !refresh && clkEn |=> cnt_r == $past(cnt_r);
  endproperty
  a_gate: assert property (p_gate) else $error("gated timer moved");

  property p_rst_hold;
    @(posedge clk_sys) disable iff (!arst_n)
      $rose(rst_r) && clkEn |-> rst_r [*8];
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset pulse too short");

  property p_rst_cnt;
    @(posedge clk_sys) disable iff (!arst_n)
      rst_r |-> hold_r != '0;
  endproperty
  a_rst_cnt: assert property (p_rst_cnt) else $error("reset without hold count");

  property p_refresh;
    @(posedge clk_sys) disable iff (!arst_n)
      refresh && clkEn |=> cnt_r == $past(reload_r);
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh did not load");

  property p_flag_set;
    @(posedge clk_sys) disable iff (!arst_n)
      ovf && clkEn |=> flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("overflow flag not set");

  property p_reload;
    @(posedge clk_sys) disable iff (!arst_n)
      ovf && !refresh && clkEn |=> cnt_r == $past(reload_r);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload on overflow");

  property p_mode_sticky;
    @(posedge clk_sys) disable iff (!arst_n)
      modeWdog |=> modeWdog;
  endproperty
  a_mode_sticky: assert property (p_mode_sticky) else $error("mode bit cleared");

  property p_irq_gate;
    @(posedge clk_sys) disable iff (!arst_n)
      irq_r |-> $past(auxIrqEnableBit) && flag_r;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

  property p_pd_halt;
    @(posedge clk_sys) disable iff (!arst_n)
      powerDown && !refresh && clkEn |=> cnt_r == $past(cnt_r);
  endproperty
  a_pd_halt: assert property (p_pd_halt) else $error("counter moved in power-down");

  property p_feed_err;
    @(posedge clk_sys) disable iff (!arst_n)
      feedErr && clkEn |=> rst_r;
  endproperty
  a_feed_err: assert property (p_feed_err) else $error("bad feed gave no reset");

  c_ovf: cover property (@(posedge clk_sys) disable iff (!arst_n) ovf);
  c_irq: cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(irq_r));
  c_rst: cover property (@(posedge clk_sys) disable iff (!arst_n) $fell(rst_r));
  c_feed_open: cover property (@(posedge clk_sys) disable iff (!arst_n) feed_r == wdt_pkg::WDT_FEED_OPEN);
  c_feed_err: cover property (@(posedge clk_sys) disable iff (!arst_n) feedErr);
endmodule
`default_nettype wire

/* File: sim/test_watchdog_interval_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_interval_timer;
  localparam int PRE = 4;
  logic        clk_sys;
  logic        arst_n;
  logic        clkEn;
  logic        auxIrqEnableBit;
  logic        powerDown;
  logic        idleMode;
  logic        clockGateOff;
  logic [5:0]  stb;
  logic [7:0]  wrData;
  logic [7:0]  ctlValue;
  logic [7:0]  reloadValue;
  logic [7:0]  counterValue;
  logic        overflowStatusFlag;
  logic        irqReq;
  logic [15:0] irqVector;
  logic [3:0]  irqPriority;
  logic        sysResetOut;
  int          errors;
  int          checked;

  wdt_core #(.PRESCALE(PRE)) wdt_core_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .clkEn(clkEn),
    .ctlWrite(stb[0]), .reloadWrite(stb[1]), .key1Write(stb[2]), .key2Write(stb[3]),
    .statusWrite(stb[4]), .otherWrite(stb[5]), .wrData(wrData), .auxIrqEnableBit(auxIrqEnableBit),
    .powerDown(powerDown), .idleMode(idleMode), .clockGateOff(clockGateOff),
    .ctlValue(ctlValue), .reloadValue(reloadValue), .counterValue(counterValue),
    .overflowStatusFlag(overflowStatusFlag), .irqReq(irqReq), .irqVector(irqVector),
    .irqPriority(irqPriority), .sysResetOut(sysResetOut)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic summarize();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Index: 0 control, 1 reload, 2 first key, 3 second key, 4 status, 5 other register.
  task automatic wr(input int idx, input logic [7:0] d);
    @(posedge clk_sys);
    stb    <= 6'h01 << idx;
    wrData <= d;
    @(posedge clk_sys);
    stb    <= 6'h00;
    #1;
  endtask

  task automatic feed();
    wr(2, 8'hFD);
    wr(3, 8'h2A);
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return overflowStatusFlag;
      1: return sysResetOut;
      default: return irqReq;
    endcase
  endfunction

  task automatic waitFor(input int s, input logic v, input int lim, output int n);
    #1;
    for (n = 0; n < lim && pick(s) !== v; n++) begin
      @(posedge clk_sys);
      #1;
    end
  endtask

  // Reports whether the counter changed over two prescaler periods, shorter than the reload period for any reload below FDH.
  task automatic moves(output logic m);
    logic [7:0] s;
    @(posedge clk_sys);
    #1;
    s = counterValue;
    repeat (2 * PRE) @(posedge clk_sys);
    #1;
    m = (counterValue !== s);
  endtask

  task automatic doReset();
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    #1;
  endtask

  task automatic tResetVals();
    chk(ctlValue, 16'h0000, "ctl after reset");
    chk(overflowStatusFlag, 16'h0000, "flag after reset");
    chk(irqVector, 16'h0053, "vector");
    chk(irqPriority, 16'h0009, "priority");
  endtask

  task automatic tTimer();
    int n;
    wr(1, 8'hFC);
    wr(0, 8'h01);
    chk(reloadValue, 16'h00FC, "reload write");
    wr(0, 8'h03);
    chk(counterValue, 16'h00FC, "refresh load");
    chk(ctlValue, 16'h0001, "refresh reads zero");
    waitFor(0, 1'b1, PRE * 8, n);
    chk(n < PRE * 8, 16'h0001, "overflow in time");
    // One cycle more than the period: the prescaler tick is registered.
    chk(16'(n), 16'((255 - 'hFC) * PRE + 1), "period");
    chk(counterValue, 16'h00FC, "reload on overflow");
    waitFor(2, 1'b1, 3, n);
    chk(irqReq, 16'h0001, "irq raised");
    wr(4, 8'h01);
    chk(overflowStatusFlag, 16'h0000, "flag cleared");
    @(posedge clk_sys);
    auxIrqEnableBit <= 1'b0;
    waitFor(0, 1'b1, PRE * 8, n);
    chk(overflowStatusFlag, 16'h0001, "keeps counting");
    repeat (2) @(posedge clk_sys);
    #1;
    chk(irqReq, 16'h0000, "irq masked");
    wr(4, 8'h01);
  endtask

  task automatic tPower();
    logic m;
    wr(0, 8'h00);
    moves(m);
    chk(m, 16'h0000, "stopped");
    wr(0, 8'h01);
    @(posedge clk_sys);
    powerDown <= 1'b1;
    moves(m);
    chk(m, 16'h0000, "power down halts");
    @(posedge clk_sys);
    powerDown    <= 1'b0;
    clockGateOff <= 1'b1;
    moves(m);
    chk(m, 16'h0000, "clock gated");
    @(posedge clk_sys);
    clockGateOff <= 1'b0;
    idleMode     <= 1'b1;
    moves(m);
    chk(m, 16'h0001, "idle counts");
    @(posedge clk_sys);
    idleMode <= 1'b0;
    clkEn    <= 1'b0;
    moves(m);
    chk(m, 16'h0000, "clock enable freezes");
    @(posedge clk_sys);
    clkEn <= 1'b1;
  endtask

  task automatic tWatchdog();
    int   n;
    logic m;
    wr(1, 8'h00);
    wr(0, 8'h02);
    wr(4, 8'h01);
    chk(overflowStatusFlag, 16'h0000, "flag clear before watchdog");
    wr(0, 8'h09);
    chk(ctlValue[3], 16'h0001, "mode set");
    wr(1, 8'h55);
    chk(reloadValue, 16'h0000, "unfed write refused");
    feed();
    wr(0, 8'h0B);
    chk(counterValue, 16'h0000, "fed refresh");
    waitFor(1, 1'b1, PRE * 260, n);
    chk(sysResetOut, 16'h0001, "watchdog reset");
    chk(overflowStatusFlag, 16'h0001, "flag on expiry");
    waitFor(1, 1'b0, 400, n);
    chk(n >= 196, 16'h0001, "reset length");
    chk(n <= 197, 16'h0001, "release at once");
    feed();
    wr(0, 8'h00);
    chk(ctlValue[3], 16'h0001, "mode sticky");
    wr(4, 8'h01);
    chk(overflowStatusFlag, 16'h0001, "unfed clear refused");
    feed();
    wr(4, 8'h01);
    chk(overflowStatusFlag, 16'h0000, "fed clear");
    wr(2, 8'hFD);
    wr(3, 8'h55);
    waitFor(1, 1'b1, 3, n);
    chk(sysResetOut, 16'h0001, "bad second key");
    waitFor(1, 1'b0, 400, n);
    chk(sysResetOut, 16'h0000, "reset released after bad key");
    feed();
    wr(5, 8'h00);
    waitFor(1, 1'b1, 3, n);
    chk(sysResetOut, 16'h0001, "bad third step");
    waitFor(1, 1'b0, 400, n);
    chk(sysResetOut, 16'h0000, "reset released after bad step");
    feed();
    wr(0, 8'h48);
    feed();
    wr(0, 8'h08);
    chk(ctlValue[6], 16'h0001, "force on sticky");
    moves(m);
    chk(m, 16'h0001, "force on runs");
    doReset();
    chk(ctlValue, 16'h0000, "power on clears mode");
  endtask

  initial begin
    errors = 0;
    checked = 0;
    arst_n = 1'b0;
    clkEn = 1'b1;
    auxIrqEnableBit = 1'b1;
    powerDown = 1'b0;
    idleMode = 1'b0;
    clockGateOff = 1'b0;
    stb = 6'h00;
    wrData = 8'h00;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    #1;
    tResetVals();
    tTimer();
    tPower();
    tWatchdog();
    summarize();
  end

  initial begin
    #300us;
    errors++;
    summarize();
  end
endmodule
`default_nettype wire
